/* File: verilog/rcb1_engine.v */
/*
 * Circular buffer mode 1 pointer manager of a remote terminal.
 * Assumes a protocol engine that decodes bus words and a single
 * shared RAM port answering each request with a one-cycle ack.
 */
// Behaviour
// R1: Mode 1 only when pingpong and circ2 bits clear and circ1 bit set.
// R2: Mode code commands never get circular handling.
// R3: Descriptor read as control, start, current, end at N..N+3.
// R4: Descriptor chosen from T/R bit, subaddress and word count or mode code.
// R5: Receive data from current+2; info and time-tag at current, current+1 after.
// R6: Transmit data fetched from current+2; info and time-tag written after.
// R7: Error-free receive: current becomes next address if not past end.
// R8: Receive past end: current reloads start; interrupt if both enables set.
// R9: Error-free transmit: current becomes next address if not past end.
// R10: Transmit past end: current reloads start; buffer-empty interrupt if enabled.
// R11: Error, busy or illegal: info and time-tag written, no data, no update; the code still moves the message's data words.
// R12: Accesses may run past end within a message; host pads 33 words.
// R13: Start and end pointers never written; only current written back.
// R14: Host initialises current equal to start.
// R15: Host leaves two reserved words before each transmit packet.
// R16: Broadcast and non-broadcast receive data share one buffer.
// R17: Broadcast select bit puts broadcast flag in info word bit 13.
// R18: Broadcast transmit to address 31: no transmit, info written, no update.
// R19: Interrupt enable of descriptor is control word bit 15.
// R20: Pointers compared as unsigned word addresses.
`timescale 1ns/1ps
`include "rcb1_defs.vh"

module rcb1_engine #(
	parameter AW = 15,
	parameter [AW-1:0] TBL_BASE = `RCB1_TBL_BASE
) (
	// Clock and reset
	input  wire          sys_clk,
	input  wire          rst,
	// Host register port
	input  wire          reg_wr,
	input  wire [15:0]   reg_addr,
	input  wire [15:0]   reg_wdata,
	output reg  [15:0]   reg_rdata,
	// Static options
	input  wire          irq_enable_bit,
	input  wire          broadcast_split_enable,
	// Protocol engine: message framing
	input  wire          msg_start,
	input  wire [15:0]   cmd_word,
	input  wire          cmd_broadcast_flag,
	input  wire          cmd_nostore,
	input  wire          msg_end,
	input  wire          msg_error,
	input  wire          msg_busy,
	input  wire          msg_illegal,
	input  wire [15:0]   info_word,
	input  wire [15:0]   time_tag,
	// Protocol engine: data words
	input  wire          rx_wr,
	input  wire [15:0]   rx_data,
	input  wire          tx_rd,
	output reg  [15:0]   tx_data,
	output reg           tx_valid,
	output reg           word_ack,
	// Protocol engine: status
	output reg           desc_ready,
	output reg           circ_active,
	output reg           tx_suppress,
	output reg           msg_done,
	output reg           message_irq_out,
	// Shared RAM port
	output reg           mem_req,
	output reg           mem_we,
	output reg  [AW-1:0] mem_addr,
	output reg  [15:0]   mem_wdata,
	input  wire          mem_ack,
	input  wire [15:0]   mem_rdata
);

	localparam [3:0] ST_IDLE   = 4'h0;
	localparam [3:0] ST_CTL    = 4'h1;
	localparam [3:0] ST_START  = 4'h2;
	localparam [3:0] ST_CUR    = 4'h3;
	localparam [3:0] ST_END    = 4'h4;
	localparam [3:0] ST_ACTIVE = 4'h5;
	localparam [3:0] ST_INFO   = 4'h6;
	localparam [3:0] ST_TT     = 4'h7;
	localparam [3:0] ST_CURWR  = 4'h8;
	localparam [3:0] ST_DONE   = 4'h9;

	reg  [3:0]    state_reg;
	reg  [15:0]   cfg2_reg;
	reg  [AW-1:0] base_reg;
	reg  [15:0]   ctl_reg;
	reg  [AW-1:0] start_reg;
	reg  [AW-1:0] cur_reg;
	reg  [AW-1:0] end_reg;
	reg  [AW-1:0] ptr_reg;
	reg           tr_reg;
	reg           broadcast_flag_reg;
	reg           mode_reg;
	reg           nostore_reg;
	reg           end_pend_reg;
	reg           fail_reg;
	reg  [15:0]   info_reg;
	reg  [15:0]   tt_reg;

	wire [4:0]    cmd_sa;
	wire [4:0]    cmd_wc;
	wire          cmd_tr;
	wire          cmd_mode;
	wire [8:0]    desc_off;
	wire [AW-1:0] desc_addr;
	wire          mode1_sel;
	wire [15:0]   info_out;
	wire [AW-1:0] new_cur;
	wire          wrapped;
	wire          end_now;
	wire          may_update;

	assign cmd_sa   = cmd_word[`RCB1_CMD_SA_HI:`RCB1_CMD_SA_LO];
	assign cmd_wc   = cmd_word[`RCB1_CMD_WC_HI:`RCB1_CMD_WC_LO];
	assign cmd_tr   = cmd_word[`RCB1_CMD_TR_BIT];
	assign cmd_mode = (cmd_sa == `RCB1_MODE_SA0) || (cmd_sa == `RCB1_MODE_SA1);

	// Subaddress blocks fill 256 words; mode code blocks sit above so none overlap
	assign desc_off  = cmd_mode ? (`RCB1_MODE_REGION | {1'b0, cmd_tr, cmd_wc, 2'h0})
	                            : {1'b0, cmd_tr, cmd_sa, 2'h0}; // R4
	assign desc_addr = TBL_BASE + {{(AW-9){1'b0}}, desc_off}; // R4

	assign mode1_sel = !mode_reg // R2
	                   && !ctl_reg[`RCB1_CTL_PINGPONG_ENABLE_BIT_BIT]
	                   && !ctl_reg[`RCB1_CTL_CIR2_BIT]
	                   && ctl_reg[`RCB1_CTL_CIR1_BIT]; // R1

	// Gap error flag slot carries the broadcast flag when selected
	assign info_out = cfg2_reg[`RCB1_CFG2_BCSEL_BIT]
	                  ? {info_reg[15:14], broadcast_flag_reg, info_reg[12:0]}
	                  : info_reg; // R17

	assign end_now    = msg_end && (state_reg != ST_IDLE);
	assign may_update = circ_active && !fail_reg && !tx_suppress && !nostore_reg; // R11 R18

	rcb1_wrap #(
		.AW(AW)
	) u_wrap (
		.next_addr(ptr_reg),
		.start_ptr(start_reg),
		.end_ptr  (end_reg),
		.new_cur  (new_cur),
		.wrapped  (wrapped)
	);

	// Host register port
	always @(posedge sys_clk) begin
		if (rst) begin
			cfg2_reg  <= `RCB1_CFG2_RESET;
			reg_rdata <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == `RCB1_CFG2_ADDR) begin
				cfg2_reg <= reg_wdata;
			end
			reg_rdata <= (reg_addr == `RCB1_CFG2_ADDR) ? cfg2_reg : 16'h0000;
		end
	end

	// Message sequencer
	always @(posedge sys_clk) begin
		if (rst) begin
			state_reg       <= ST_IDLE;
			base_reg        <= {AW{1'b0}};
			ctl_reg         <= 16'h0000;
			start_reg       <= {AW{1'b0}};
			cur_reg         <= {AW{1'b0}};
			end_reg         <= {AW{1'b0}};
			ptr_reg         <= {AW{1'b0}};
			tr_reg          <= 1'b0;
			broadcast_flag_reg       <= 1'b0;
			mode_reg        <= 1'b0;
			nostore_reg     <= 1'b0;
			end_pend_reg    <= 1'b0;
			fail_reg        <= 1'b0;
			info_reg        <= 16'h0000;
			tt_reg          <= 16'h0000;
			tx_data         <= 16'h0000;
			tx_valid        <= 1'b0;
			word_ack        <= 1'b0;
			desc_ready      <= 1'b0;
			circ_active     <= 1'b0;
			tx_suppress     <= 1'b0;
			msg_done        <= 1'b0;
			message_irq_out <= 1'b0;
			mem_req         <= 1'b0;
			mem_we          <= 1'b0;
			mem_addr        <= {AW{1'b0}};
			mem_wdata       <= 16'h0000;
		end else begin
			tx_valid        <= 1'b0;
			word_ack        <= 1'b0;
			desc_ready      <= 1'b0;
			msg_done        <= 1'b0;
			message_irq_out <= 1'b0;
			// End of message is latched so it is not lost behind a RAM access
			if (end_now && state_reg <= ST_ACTIVE) begin
				end_pend_reg <= 1'b1;
				fail_reg     <= msg_error || msg_busy || msg_illegal; // R11
				info_reg     <= info_word;
				tt_reg       <= time_tag;
			end
			case (state_reg)
			ST_IDLE: begin
				if (msg_start) begin
					tr_reg       <= cmd_tr;
					broadcast_flag_reg    <= cmd_broadcast_flag;
					mode_reg     <= cmd_mode;
					nostore_reg  <= cmd_nostore;
					end_pend_reg <= 1'b0;
					fail_reg     <= 1'b0;
					tx_suppress  <= 1'b0;
					circ_active  <= 1'b0;
					base_reg     <= desc_addr;
					mem_addr     <= desc_addr; // R3
					mem_we       <= 1'b0;
					mem_req      <= 1'b1;
					state_reg    <= ST_CTL;
				end
			end
			ST_CTL: begin
				if (mem_ack) begin
					ctl_reg   <= mem_rdata;
					mem_addr  <= base_reg + {{(AW-2){1'b0}}, `RCB1_DESC_START}; // R3
					state_reg <= ST_START;
				end
			end
			ST_START: begin
				if (mem_ack) begin
					start_reg <= mem_rdata[AW-1:0];
					mem_addr  <= base_reg + {{(AW-2){1'b0}}, `RCB1_DESC_CUR}; // R3
					state_reg <= ST_CUR;
				end
			end
			ST_CUR: begin
				if (mem_ack) begin
					cur_reg   <= mem_rdata[AW-1:0];
					mem_addr  <= base_reg + {{(AW-2){1'b0}}, `RCB1_DESC_END}; // R3
					state_reg <= ST_END;
				end
			end
			ST_END: begin
				if (mem_ack) begin
					end_reg     <= mem_rdata[AW-1:0];
					mem_req     <= 1'b0;
					ptr_reg     <= cur_reg + {{(AW-2){1'b0}}, `RCB1_DATA_OFS}; // R5 R6
					circ_active <= mode1_sel; // R1 R2
					// Broadcast transmit is not answered on the bus in circular mode 1
					tx_suppress <= mode1_sel && tr_reg && broadcast_flag_reg; // R18
					desc_ready  <= 1'b1;
					state_reg   <= ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (mem_req) begin
					if (mem_ack) begin
						mem_req  <= 1'b0;
						word_ack <= 1'b1;
						// Runs past end_pointer freely until the message ends
						ptr_reg  <= ptr_reg + {{(AW-1){1'b0}}, 1'b1}; // R12
						if (!mem_we) begin
							tx_data  <= mem_rdata;
							tx_valid <= 1'b1;
						end
					end
				end else if (end_pend_reg) begin
					end_pend_reg <= 1'b0;
					if (circ_active) begin
						mem_req   <= 1'b1;
						mem_we    <= 1'b1;
						mem_addr  <= cur_reg; // R5 R6 R11 R18
						mem_wdata <= info_out; // R17
						state_reg <= ST_INFO;
					end else begin
						state_reg <= ST_DONE;
					end
				end else if (word_ack) begin
					// The served request still stands while its ack shows; never take it twice
				end else if (rx_wr && circ_active && !tr_reg && !nostore_reg) begin
					// Broadcast receive shares the buffer whatever the split option
					mem_req   <= 1'b1; // R16
					mem_we    <= 1'b1;
					mem_addr  <= ptr_reg; // R5
					mem_wdata <= rx_data;
				end else if (tx_rd && circ_active && tr_reg && !tx_suppress && !nostore_reg) begin
					mem_req  <= 1'b1;
					mem_we   <= 1'b0;
					mem_addr <= ptr_reg; // R6
				end else if ((rx_wr || tx_rd) && !circ_active) begin
					// Other buffer modes are served elsewhere; keep the engine moving
					word_ack <= 1'b1;
				end
			end
			ST_INFO: begin
				if (mem_ack) begin
					mem_addr  <= cur_reg + {{(AW-1){1'b0}}, 1'b1}; // R5 R6
					mem_wdata <= tt_reg;
					state_reg <= ST_TT;
				end
			end
			ST_TT: begin
				if (mem_ack) begin
					if (may_update) begin
						// Only current_pointer is ever written back
						mem_addr  <= base_reg + {{(AW-2){1'b0}}, `RCB1_DESC_CUR}; // R13
						mem_wdata <= {{(16-AW){1'b0}}, new_cur}; // R7 R8 R9 R10
						state_reg <= ST_CURWR;
					end else begin
						mem_req   <= 1'b0; // R11 R18
						state_reg <= ST_DONE;
					end
				end
			end
			ST_CURWR: begin
				if (mem_ack) begin
					mem_req         <= 1'b0;
					cur_reg         <= new_cur;
					message_irq_out <= wrapped && ctl_reg[`RCB1_CTL_IRQ_BIT] // R19
					                   && irq_enable_bit; // R8 R10
					state_reg       <= ST_DONE;
				end
			end
			ST_DONE: begin
				msg_done    <= 1'b1;
				circ_active <= 1'b0;
				tx_suppress <= 1'b0;
				state_reg   <= ST_IDLE;
			end
			default: begin
				mem_req   <= 1'b0;
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

endmodule // rcb1_engine

/* File: pkg/rcb1_defs.vh */
/*
 * Constants for the circular mode 1 buffer pointer manager.
 * Assumes word-addressed shared RAM and 16-bit command and status words.
 */
`ifndef RCB1_DEFS_VH
`define RCB1_DEFS_VH

// Register map
`define RCB1_CFG2_ADDR      16'h0001
`define RCB1_CFG2_RESET     16'h0000
`define RCB1_CFG2_BCSEL_BIT 3

// Descriptor word offsets from base N
`define RCB1_DESC_CTL       2'h0
`define RCB1_DESC_START     2'h1
`define RCB1_DESC_CUR       2'h2
`define RCB1_DESC_END       2'h3

// Descriptor control word fields
`define RCB1_CTL_IRQ_BIT    15
`define RCB1_CTL_PINGPONG_ENABLE_BIT_BIT   2
`define RCB1_CTL_CIR2_BIT   1
`define RCB1_CTL_CIR1_BIT   0

// Message information word
`define RCB1_INFO_BROADCAST_FLAG_BIT 13

// Command word fields
`define RCB1_CMD_RT_HI      15
`define RCB1_CMD_RT_LO      11
`define RCB1_CMD_TR_BIT     10
`define RCB1_CMD_SA_HI      9
`define RCB1_CMD_SA_LO      5
`define RCB1_CMD_WC_HI      4
`define RCB1_CMD_WC_LO      0
`define RCB1_BROADCAST_FLAG_RT       5'h1f
`define RCB1_MODE_SA0       5'h00
`define RCB1_MODE_SA1       5'h1f

// Descriptor table layout
`define RCB1_TBL_BASE       15'h0400
`define RCB1_MODE_REGION    9'h100

// Record layout: info word, time-tag word, then data
`define RCB1_DATA_OFS       2'h2

`endif

/* File: verilog/rcb1_wrap.v */
/*
 * Next current_pointer choice after an error-free message.
 * Assumes pointers are plain unsigned word addresses in one RAM space.
 */
`timescale 1ns/1ps

module rcb1_wrap #(
	parameter AW = 15
) (
	// Pointers
	input  wire [AW-1:0] next_addr,
	input  wire [AW-1:0] start_ptr,
	input  wire [AW-1:0] end_ptr,
	// Result
	output wire [AW-1:0] new_cur,
	output wire          wrapped
);

	// Unsigned compare; a record may run past end_pointer before the wrap
	assign wrapped = (next_addr > end_ptr); // R20
	assign new_cur = wrapped ? start_ptr : next_addr; // R7

endmodule // rcb1_wrap

/* File: dv/rcb1_ram_model.sv */
/* Shared RAM model for the pointer manager's request port.
 * Assumes one request held until ack; slow adds two wait cycles. */
`timescale 1ns/1ps

module rcb1_ram_model (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// Request
	input  wire        slow,
	input  wire        mem_req,
	input  wire        mem_we,
	input  wire [14:0] mem_addr,
	input  wire [15:0] mem_wdata,
	// Answer
	output reg         mem_ack,
	output wire [15:0] mem_rdata
);
	reg [15:0] mem [0:32767];
	reg [15:0] q_reg;
	reg [1:0]  wait_reg;
	integer    i;

	initial for (i = 0; i < 32768; i = i + 1) mem[i] = 16'h0000;
	// Outside ack the bus shows the inverse, so stale data never looks right
	assign mem_rdata = mem_ack ? q_reg : ~q_reg;

	always @(posedge sys_clk) begin
		mem_ack <= 1'b0;
		if (rst) begin
			wait_reg <= 2'h0;
			q_reg    <= 16'h0000;
		end else if (mem_req && !mem_ack) begin
			if (wait_reg == {slow, 1'b0}) begin
				mem_ack  <= 1'b1;
				wait_reg <= 2'h0;
				q_reg    <= mem[mem_addr];
				// Any address accepted, also past the buffer end
				if (mem_we) mem[mem_addr] <= mem_wdata;
			end else begin
				wait_reg <= wait_reg + 2'h1;
			end
		end
	end
endmodule // rcb1_ram_model

/* File: dv/rcb1_engine_chk.sv */
/* Port checker for the circular mode 1 pointer manager.
 * Assumes binding to the engine top; sees only its ports. */
`timescale 1ns/1ps

module rcb1_engine_chk #(
	parameter AW = 15,
	parameter [AW-1:0] TBL_BASE = 15'h0400
) (
	input wire          sys_clk,
	input wire          rst,
	input wire [15:0]   reg_addr,
	input wire [15:0]   reg_rdata,
	input wire          irq_enable_bit,
	input wire          word_ack,
	input wire          tx_valid,
	input wire          desc_ready,
	input wire          circ_active,
	input wire          tx_suppress,
	input wire          msg_done,
	input wire          message_irq_out,
	input wire          mem_req,
	input wire          mem_we,
	input wire [AW-1:0] mem_addr,
	input wire [15:0]   mem_wdata,
	input wire          mem_ack
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_wdata)) else $error("RAM request changed before ack");
	chk_desc_last_word: assert property (desc_ready |-> $past(mem_ack)
		&& $past(mem_addr[1:0]) == 2'h3 && !$past(mem_we)) else $error("Descriptor not ended at N+3");
	chk_limits_readonly: assert property (mem_req && mem_we |->
		!(mem_addr[AW-1:9] == TBL_BASE[AW-1:9] && mem_addr[0])) else $error("Start or end written");
	chk_data_via_ram: assert property (circ_active && word_ack && !tx_suppress |->
		$past(mem_ack)) else $error("Data word acked without RAM access");
	chk_irq_gated: assert property (message_irq_out |-> irq_enable_bit && circ_active)
		else $error("Interrupt without enable");
	chk_irq_then_done: assert property (message_irq_out |=> msg_done)
		else $error("Interrupt not followed by done");
	chk_done_idle: assert property (msg_done |=> !circ_active && !tx_suppress && !msg_done)
		else $error("Status not cleared after done");
	chk_suppress_quiet: assert property (tx_suppress |-> !tx_valid)
		else $error("Transmit word during suppression");
	chk_unmapped_zero: assert property ($past(reg_addr) != 16'h0001 |-> reg_rdata == 16'h0000)
		else $error("Unmapped read not zero");

	cov_wrap_irq: cover property (message_irq_out);
	cov_suppress: cover property (tx_suppress);
	cov_not_circ: cover property (desc_ready && !circ_active);
endmodule // rcb1_engine_chk

/* File: dv/rcb1_engine_test.sv */
/* Self-checking bench for the circular mode 1 pointer manager.
 * Assumes the RAM model as partner; host setup writes RAM directly. */
`timescale 1ns/1ps

module rcb1_engine_test;
	reg         sys_clk, rst, reg_wr, irq_enable_bit, broadcast_split_enable, msg_start;
	reg         cmd_broadcast_flag, cmd_nostore, msg_end, msg_error, msg_busy, msg_illegal;
	reg         rx_wr, tx_rd, slow, circ, supp;
	reg  [15:0] reg_addr, reg_wdata, cmd_word, rx_data, info_word, time_tag;
	wire [15:0] reg_rdata, tx_data, mem_wdata, mem_rdata;
	wire [14:0] mem_addr;
	wire        tx_valid, word_ack, desc_ready, circ_active, tx_suppress, msg_done;
	wire        message_irq_out, mem_req, mem_we, mem_ack;
	integer     err_total, checks_done, irqs, k;
	reg  [15:0] txq [$];

	rcb1_engine DUT (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_enable_bit(irq_enable_bit),
		.broadcast_split_enable(broadcast_split_enable), .msg_start(msg_start),
		.cmd_word(cmd_word), .cmd_broadcast_flag(cmd_broadcast_flag), .cmd_nostore(cmd_nostore),
		.msg_end(msg_end), .msg_error(msg_error), .msg_busy(msg_busy),
		.msg_illegal(msg_illegal), .info_word(info_word), .time_tag(time_tag),
		.rx_wr(rx_wr), .rx_data(rx_data), .tx_rd(tx_rd), .tx_data(tx_data),
		.tx_valid(tx_valid), .word_ack(word_ack), .desc_ready(desc_ready),
		.circ_active(circ_active), .tx_suppress(tx_suppress), .msg_done(msg_done),
		.message_irq_out(message_irq_out), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	rcb1_ram_model ram (.sys_clk(sys_clk), .rst(rst), .slow(slow), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		if (tx_valid === 1'b1) txq.push_back(tx_data);
		if (message_irq_out === 1'b1) irqs = irqs + 1;
		if (desc_ready === 1'b1) circ = circ_active;
		if (tx_suppress === 1'b1) supp = 1'b1;
	end

	task test_done;
		begin
			if (err_total == 0 && checks_done > 0) $display("Test passed");
			else $display("Test failed");
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("MISMATCH %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tick_until(input integer s);
		integer i;
		begin
			i = 0;
			do begin
				@(negedge sys_clk);
				i = i + 1;
			end while (i < 300 && (s == 0 ? desc_ready : s == 1 ? word_ack : msg_done) !== 1'b1);
			if (i >= 300) begin
				err_total = err_total + 1;
				test_done;
			end
		end
	endtask
	task reg_write(input [15:0] a, input [15:0] d);
		begin
			@(posedge sys_clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task reg_read(input [15:0] a, input [15:0] e);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			@(posedge sys_clk);
			@(negedge sys_clk);
			chk(reg_rdata, e);
		end
	endtask
	function [14:0] dx(input tr, input [4:0] sa);
		dx = 15'h0400 + {7'h00, tr, sa, 2'b00};
	endfunction
	// Host side of descriptor setup: current starts equal to start
	task setd(input tr, input [4:0] sa, input [15:0] ctl, input [15:0] s, input [15:0] e);
		begin
			ram.mem[dx(tr, sa)] = ctl;
			ram.mem[dx(tr, sa) + 15'h1] = s;
			ram.mem[dx(tr, sa) + 15'h2] = s;
			ram.mem[dx(tr, sa) + 15'h3] = e;
		end
	endtask
	task run(input tr, input [4:0] sa, input integer n, input bc, input er);
		integer j;
		begin
			@(posedge sys_clk);
			cmd_word <= {(bc ? 5'h1f : 5'h05), tr, sa, n[4:0]};
			cmd_broadcast_flag <= bc;
			msg_start <= 1'b1;
			supp = 1'b0;
			@(posedge sys_clk);
			msg_start <= 1'b0;
			tick_until(0);
			for (j = 0; j < n; j = j + 1) begin
				@(posedge sys_clk);
				rx_wr <= !tr;
				tx_rd <= tr;
				rx_data <= 16'ha000 + j[15:0];
				tick_until(1);
				@(posedge sys_clk);
				rx_wr <= 1'b0;
				tx_rd <= 1'b0;
			end
			@(posedge sys_clk);
			msg_end <= 1'b1;
			msg_error <= er;
			@(posedge sys_clk);
			msg_end <= 1'b0;
			msg_error <= 1'b0;
			tick_until(2);
		end
	endtask

	initial begin
		{reg_wr, msg_start, cmd_broadcast_flag, cmd_nostore, msg_end, msg_error, msg_busy} = 7'h00;
		{msg_illegal, rx_wr, tx_rd, slow, circ, supp} = 6'h00;
		{reg_addr, reg_wdata, cmd_word, rx_data} = 64'h0;
		info_word = 16'h1234;
		time_tag = 16'h5678;
		irq_enable_bit = 1'b1;
		broadcast_split_enable = 1'b1;
		err_total = 0;
		checks_done = 0;
		irqs = 0;
		rst = 1'b1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		reg_write(16'h0002, 16'hffff);
		reg_write(16'h0001, 16'h0008);
		reg_read(16'h0001, 16'h0008);
		reg_read(16'h0002, 16'h0000);
		setd(0, 1, 16'h8001, 16'h1000, 16'h1010);
		run(0, 1, 3, 1, 0);
		chk({15'h0, circ}, 16'h0001);
		for (k = 0; k < 3; k = k + 1) chk(ram.mem[15'h1002 + k], 16'ha000 + k);
		chk(ram.mem[15'h1000], 16'h3234);
		chk(ram.mem[15'h1001], 16'h5678);
		chk(ram.mem[dx(0, 1) + 15'h2], 16'h1005);
		chk(ram.mem[dx(0, 1) + 15'h1], 16'h1000);
		chk(ram.mem[dx(0, 1) + 15'h3], 16'h1010);
		run(0, 1, 9, 0, 0);
		chk(ram.mem[dx(0, 1) + 15'h2], 16'h1010);
		chk(irqs[15:0], 16'h0000);
		run(0, 1, 1, 0, 0);
		chk(ram.mem[dx(0, 1) + 15'h2], 16'h1000);
		chk(irqs[15:0], 16'h0001);
		chk(ram.mem[15'h1012], 16'ha000);
		run(0, 1, 2, 0, 1);
		chk(ram.mem[dx(0, 1) + 15'h2], 16'h1000);
		chk(ram.mem[15'h1000], 16'h1234);
		msg_busy <= 1'b1;
		run(0, 1, 2, 0, 0);
		msg_busy <= 1'b0;
		chk(ram.mem[dx(0, 1) + 15'h2], 16'h1000);
		slow <= 1'b1;
		irq_enable_bit <= 1'b0;
		setd(1, 2, 16'h8001, 16'h2000, 16'h2010);
		ram.mem[15'h2002] = 16'hc000;
		ram.mem[15'h2003] = 16'hc001;
		run(1, 2, 2, 0, 0);
		chk(txq.size(), 16'h0002);
		chk(txq[0], 16'hc000);
		chk(txq[1], 16'hc001);
		chk(ram.mem[15'h2000], 16'h1234);
		chk(ram.mem[dx(1, 2) + 15'h2], 16'h2004);
		run(1, 2, 0, 1, 0);
		chk({15'h0, supp}, 16'h0001);
		chk(ram.mem[15'h2004], 16'h3234);
		chk(ram.mem[dx(1, 2) + 15'h2], 16'h2004);
		run(1, 2, 12, 0, 0);
		chk(ram.mem[dx(1, 2) + 15'h2], 16'h2000);
		chk(irqs[15:0], 16'h0001);
		setd(0, 3, 16'h0005, 16'h3000, 16'h3010);
		run(0, 3, 0, 0, 0);
		chk({15'h0, circ}, 16'h0000);
		ram.mem[15'h0500] = 16'h8001;
		run(0, 0, 0, 0, 0);
		chk({15'h0, circ}, 16'h0000);
		test_done;
	end
endmodule // rcb1_engine_test

bind rcb1_engine rcb1_engine_chk #(.AW(AW), .TBL_BASE(TBL_BASE)) u_chk (.sys_clk(sys_clk),
	.rst(rst), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .irq_enable_bit(irq_enable_bit),
	.word_ack(word_ack), .tx_valid(tx_valid), .desc_ready(desc_ready),
	.circ_active(circ_active), .tx_suppress(tx_suppress), .msg_done(msg_done),
	.message_irq_out(message_irq_out), .mem_req(mem_req), .mem_we(mem_we),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack));
